//--- mmtc_timer.sv
// three independent multimode timer channels behind an APB slave
`timescale 1ns/100ps
module mmtc_timer
    import mmtc_pkg::*;
#(
    parameter int NCH = 3
) (
    // clock and reset
    input wire logic clock,
    input wire logic nrst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // count sources
    input wire logic subClockDiv32Tick,
    input wire logic peerTimerBOneOvf,
    input wire logic peerTimerAZeroOvf,
    // channel pins
    input wire logic [NCH-1:0] channelIoPinIn,
    output logic [NCH-1:0] channelIoPinOut,
    output logic [NCH-1:0] channelIoPinOe,
    // interrupt requests and acknowledges
    output logic [NCH-1:0] irqRequest,
    input wire logic [NCH-1:0] irqAck,
    output logic [NCH-1:0] timerOverflow
);

    if (NCH < 1 || NCH > 8) begin : g_bad
        $error("mmtc_timer: NCH must be 1 to 8");
    end

    ////////////////////////////////////////////////////////////////////////
    // apb decode

    function automatic logic hitChan(input logic [ADDR_W-1:0] a,
                                     input logic [7:0] base, input int ch);
        hitChan = (a == base + 8'(4 * ch));
    endfunction

    logic access;
    logic wrEn;
    logic mapped;
    logic [NCH-1:0] startFlag;
    logic [NCH-1:0] oneShotWr;
    logic [NCH-1:0] irqClrWr;
    logic [NCH-1:0] timerWr;
    logic [NCH-1:0] modeWr;
    logic [15:0] readTimer [NCH];
    logic [MODE_W:0] readMode [NCH];
    logic [31:0] next_prdata;

    assign access = psel && penable;
    assign wrEn = access && pwrite;
    assign pready = 1'b1;

    always_comb begin
        mapped = (paddr == OFS_START) || (paddr == OFS_ONESHOT)
            || (paddr == OFS_IRQ);
        next_prdata = 32'h0000_0000;
        if (paddr == OFS_START) begin
            next_prdata[NCH-1:0] = startFlag;
        end
        if (paddr == OFS_IRQ) begin
            next_prdata[NCH-1:0] = irqRequest;
        end
        for (int i = 0; i < NCH; i++) begin
            if (hitChan(paddr, OFS_TIMER, i)) begin
                mapped = 1'b1;
                next_prdata[15:0] = readTimer[i];
            end
            if (hitChan(paddr, OFS_MODE, i)) begin
                mapped = 1'b1;
                next_prdata[MODE_W:0] = readMode[i];
            end
        end
    end

    assign pslverr = access && !mapped;

    // read data captured in the setup cycle, stable through access
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable) begin
            prdata <= next_prdata;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            startFlag <= '0;
        end else if (wrEn && paddr == OFS_START) begin
            startFlag <= pwdata[NCH-1:0];
        end
    end

    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            oneShotWr[i] = wrEn && paddr == OFS_ONESHOT && pwdata[i];
            irqClrWr[i] = wrEn && paddr == OFS_IRQ && pwdata[i];
            timerWr[i] = wrEn && hitChan(paddr, OFS_TIMER, i);
            modeWr[i] = wrEn && hitChan(paddr, OFS_MODE, i);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // prescaler

    logic [4:0] prescale;
    logic tickDiv8;
    logic tickDiv32;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            prescale <= 5'h00;
        end else begin
            prescale <= prescale + 5'h01;
        end
    end

    assign tickDiv8 = (prescale[2:0] == DIV8_LAST[2:0]);
    assign tickDiv32 = (prescale == DIV32_LAST);

    ////////////////////////////////////////////////////////////////////////
    // channels

    logic [NCH-1:0] chanUnder;

    for (genvar i = 0; i < NCH; i++) begin : g_ch
        logic [MODE_W-1:0] modeReg;
        mmtc_mode_t mode;
        mmtc_src_t src;
        logic [15:0] counter;
        logic [15:0] reload;
        logic pinOut;
        logic pinPrev;
        logic startPrev;
        logic running;
        logic retrig;
        logic measStarted;
        logic measValid;
        logic ovfFlag;
        logic irqBit;
        logic intTick;
        logic peerOvf;
        logic pinFall;
        logic pinRise;
        logic srcTick;
        logic trig;
        logic measEdge;
        logic start;
        logic under;
        logic setIrq;
        logic upCount;
        logic underQ;

        assign mode = mmtc_mode_t'(modeReg[MF_MODE +: 2]);
        assign src = mmtc_src_t'(modeReg[MF_SRC +: 2]);
        assign start = startFlag[i];
        assign upCount = modeReg[MF_UP];
        assign pinFall = pinPrev && !channelIoPinIn[i];
        assign pinRise = !pinPrev && channelIoPinIn[i];

        always_comb begin
            unique case (mmtc_clk_t'(modeReg[MF_CLK +: 2]))
                CK_DIV1: intTick = 1'b1;
                CK_DIV8: intTick = tickDiv8;
                CK_DIV32: intTick = tickDiv32;
                CK_SUB32: intTick = subClockDiv32Tick;
            endcase
        end

        // peer overflow: timer b one, timer a zero, or neighbouring channel
        always_comb begin
            unique case (modeReg[MF_PEER +: 2])
                2'b00: peerOvf = peerTimerBOneOvf;
                2'b01: peerOvf = peerTimerAZeroOvf;
                default: peerOvf = chanUnder[(i + NCH - 1) % NCH];
            endcase
        end

        always_comb begin
            srcTick = intTick;
            trig = oneShotWr[i];
            measEdge = 1'b0;
            unique case (mode)
                MD_EVENT: srcTick = (src == SRC_FALL) ? pinFall
                    : (src == SRC_RISE) ? pinRise : peerOvf;
                MD_ONESHOT: trig = (src == SRC_FALL) ? pinFall
                    : (src == SRC_RISE) ? pinRise
                    : (src == SRC_PEER) ? peerOvf : oneShotWr[i];
                MD_MEASURE: measEdge = (src == SRC_FALL) ? pinFall
                    : (src == SRC_RISE) ? pinRise : (pinFall || pinRise);
                MD_TIMER: srcTick = intTick;
            endcase
        end

        // up count ends at all-ones, down count at zero
        assign under = start && srcTick
            && (mode == MD_TIMER || mode == MD_EVENT)
            && (counter == ((mode == MD_EVENT && upCount) ? CNT_ALL
                : CNT_ZERO));
        assign chanUnder[i] = underQ;

        always_ff @(posedge clock or negedge nrst) begin
            if (!nrst) begin
                pinPrev <= 1'b1;
                startPrev <= 1'b0;
                underQ <= 1'b0;
                modeReg <= MODE_RESET;
            end else begin
                pinPrev <= channelIoPinIn[i];
                underQ <= under;
                startPrev <= start;
                if (modeWr[i]) begin
                    modeReg <= pwdata[MODE_W-1:0];
                end
            end
        end

        // counter, reload and one-shot state
        always_ff @(posedge clock or negedge nrst) begin
            if (!nrst) begin
                counter <= CNT_ZERO;
                reload <= CNT_ZERO;
                running <= 1'b0;
                retrig <= 1'b0;
                measStarted <= 1'b0;
                measValid <= 1'b0;
            end else begin
                // write while counting goes to reload only
                if (timerWr[i] && mode != MD_MEASURE) begin
                    reload <= pwdata[15:0];
                    if (!start) begin
                        counter <= pwdata[15:0];
                    end
                end
                unique case (mode)
                    MD_TIMER, MD_EVENT: begin
                        if (start && srcTick) begin
                            if (under && modeReg[MF_FREE]
                                && mode == MD_EVENT) begin
                                counter <= upCount ? CNT_ZERO : CNT_ALL;
                            end else if (under) begin
                                counter <= reload;
                            end else if (mode == MD_EVENT && upCount) begin
                                counter <= counter + CNT_ONE;
                            end else begin
                                counter <= counter - CNT_ONE;
                            end
                        end
                    end
                    MD_ONESHOT: begin
                        if (!start) begin
                            // stop and reload on start clear
                            running <= 1'b0;
                            retrig <= 1'b0;
                            if (startPrev) begin
                                counter <= reload;
                            end
                        end else if (!running) begin
                            if (trig) begin
                                running <= 1'b1;
                                counter <= reload;
                            end
                        end else begin
                            if (trig) begin
                                retrig <= 1'b1;
                            end
                            if (intTick) begin
                                if (retrig) begin
                                    counter <= reload;
                                    retrig <= 1'b0;
                                end else if (counter <= CNT_ONE) begin
                                    counter <= reload;
                                    running <= 1'b0;
                                end else begin
                                    counter <= counter - CNT_ONE;
                                end
                            end
                        end
                    end
                    MD_MEASURE: begin
                        if (start && !startPrev) begin
                            measStarted <= 1'b0;
                            measValid <= 1'b0;
                        end
                        if (start) begin
                            if (measEdge && !measStarted) begin
                                counter <= CNT_ZERO;
                                measStarted <= 1'b1;
                            end else if (measEdge) begin
                                reload <= counter;
                                counter <= CNT_ZERO;
                                measValid <= 1'b1;
                            end else if (intTick) begin
                                counter <= counter + CNT_ONE;
                            end
                        end
                    end
                endcase
            end
        end

        // request set causes per mode
        always_comb begin
            unique case (mode)
                MD_TIMER, MD_EVENT: setIrq = under;
                MD_ONESHOT: setIrq = (!start && startPrev)
                    || (start && running && intTick && !retrig
                        && counter <= CNT_ONE);
                MD_MEASURE: setIrq = start && ((measEdge && measStarted)
                    || (!measEdge && intTick && counter == CNT_ALL));
            endcase
        end

        // sticky request, set wins over clear
        always_ff @(posedge clock or negedge nrst) begin
            if (!nrst) begin
                irqBit <= 1'b0;
            end else if (setIrq) begin
                irqBit <= 1'b1;
            end else if (irqClrWr[i] || irqAck[i]) begin
                irqBit <= 1'b0;
            end
        end

        // overflow flag, hardware set beats the mode-write clear
        always_ff @(posedge clock or negedge nrst) begin
            if (!nrst) begin
                ovfFlag <= 1'b0;
            end else if (mode == MD_MEASURE && start && !measEdge
                         && intTick && counter == CNT_ALL) begin
                ovfFlag <= 1'b1;
            end else if (modeWr[i] && start) begin
                ovfFlag <= 1'b0;
            end
        end

        // pin drive
        always_ff @(posedge clock or negedge nrst) begin
            if (!nrst) begin
                pinOut <= 1'b0;
            end else if (!start) begin
                pinOut <= 1'b0;
            end else if (mode == MD_ONESHOT) begin
                if (!running && trig) begin
                    pinOut <= 1'b1;
                end else if (running && intTick && !retrig
                             && counter <= CNT_ONE) begin
                    pinOut <= 1'b0;
                end
            end else if (under) begin
                pinOut <= !pinOut;
            end
        end

        // pin inputs and pulse output are exclusive
        assign channelIoPinOe[i] = modeReg[MF_PULSE] && mode != MD_MEASURE
            && !(mode == MD_EVENT && src != SRC_PEER)
            && !(mode == MD_ONESHOT && src <= SRC_RISE);
        assign channelIoPinOut[i] = pinOut && channelIoPinOe[i];
        assign irqRequest[i] = irqBit;
        assign timerOverflow[i] = under;
        // measurement reads zero until a capture exists
        assign readTimer[i] = (mode != MD_MEASURE) ? counter
            : measValid ? reload : CNT_ZERO;
        assign readMode[i] = {ovfFlag, modeReg};
    end

endmodule

//--- mmtc_pkg.sv
// constants for the multimode timer channel block
//
// Notes on behaviour
// - timer mode: start flag one makes counter decrement each count tick
// - timer underflow reloads, keeps counting, sets request, toggles pin
// - timer with pulse output: clearing start freezes count, pin low
// - timer and event modes: clearing start holds the count
// - event source: pin falling edge, pin rising edge, or peer overflow
// - event mode: counter advances on each selected source edge
// - event reload type: underflow reloads, keeps counting, sets request
// - event free-run: underflow wraps without reload, sets request
// - one-shot trigger: pin falling/rising edge, peer overflow, software
// - one-shot trigger with start set begins count, pin driven high
// - one-shot reaching zero: pin low, reload, stop, set request
// - one-shot retrigger reloads on next count tick, count continues
// - one-shot start cleared: stop, reload, pin low, set request
// - measurement: fall-to-fall, rise-to-rise, or width between edges
// - measurement: start flag one makes counter count internal ticks
// - first effective edge clears counter, no request raised
// - later edges capture count into reload, set request, clear counter
// - request on edge or overflow; overflow flag tells causes apart
// - counter not initialised at measurement start
// - mode write while started clears overflow flag; never set by software
// - internal sources: main clock /1, /8, /32, sub clock /32
// - ratio value+1 down, all-ones minus value plus one up, one-shot value
// - timer write while counting updates reload only, else both
// - measurement ignores timer writes; reads valid after second edge
package mmtc_pkg;
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFS_START = 8'h00;
    localparam logic [7:0] OFS_ONESHOT = 8'h04;
    localparam logic [7:0] OFS_IRQ = 8'h08;
    localparam logic [7:0] OFS_TIMER = 8'h10;
    localparam logic [7:0] OFS_MODE = 8'h20;
    localparam logic [15:0] CNT_ZERO = 16'h0000;
    localparam logic [15:0] CNT_ONE = 16'h0001;
    localparam logic [15:0] CNT_ALL = 16'hFFFF;
    localparam logic [4:0] DIV8_LAST = 5'h07;
    localparam logic [4:0] DIV32_LAST = 5'h1F;
    // mode register field positions
    localparam int MF_MODE = 0;
    localparam int MF_PULSE = 2;
    localparam int MF_CLK = 3;
    localparam int MF_FREE = 5;
    localparam int MF_SRC = 6;
    localparam int MF_PEER = 8;
    localparam int MF_UP = 10;
    localparam int MF_OVF = 11;
    localparam int MODE_W = 11;
    localparam logic [10:0] MODE_RESET = 11'h000;

    typedef enum logic [1:0] {
        MD_TIMER = 2'b00,
        MD_EVENT = 2'b01,
        MD_ONESHOT = 2'b10,
        MD_MEASURE = 2'b11
    } mmtc_mode_t;

    // pin source / trigger / measurement edge selection
    typedef enum logic [1:0] {
        SRC_FALL = 2'b00,
        SRC_RISE = 2'b01,
        SRC_PEER = 2'b10,
        SRC_SOFT = 2'b11
    } mmtc_src_t;

    typedef enum logic [1:0] {
        CK_DIV1 = 2'b00,
        CK_DIV8 = 2'b01,
        CK_DIV32 = 2'b10,
        CK_SUB32 = 2'b11
    } mmtc_clk_t;
endpackage

//--- mmtc_timer_sva.sv
// assertion checker for the multimode timer channel, channel zero
`timescale 1ns/100ps
module mmtc_timer_sva
    import mmtc_pkg::*;
#(
    parameter int NCH = 3
) (
    // clock and reset
    input wire logic clock,
    input wire logic nrst,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pslverr,
    // channel side
    input wire logic [NCH-1:0] channelIoPinOut,
    input wire logic [NCH-1:0] channelIoPinOe,
    input wire logic [NCH-1:0] irqRequest,
    input wire logic [NCH-1:0] irqAck,
    input wire logic [NCH-1:0] timerOverflow
);
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    ////////////////////////////////////////////////////////////////////////
    // bus shadow of start flag and mode, so checks know the mode
    logic wrDone;
    logic start0;
    logic [2:0] mode0;
    assign wrDone = psel && penable && pwrite && !pslverr;
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            start0 <= 1'b0;
        end else if (wrDone && paddr == OFS_START) begin
            start0 <= pwdata[0];
        end
    end
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            mode0 <= 3'h0;
        end else if (wrDone && paddr == OFS_MODE) begin
            mode0 <= pwdata[2:0];
        end
    end
    ////////////////////////////////////////////////////////////////////////
    property p_sticky;
        irqRequest[0] && !irqAck[0] && !(wrDone && paddr == OFS_IRQ)
            |=> irqRequest[0];
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("request dropped without clear");
    property p_ovf_irq;
        timerOverflow[0] |=> irqRequest[0];
    endproperty
    a_ovf_irq: assert property (p_ovf_irq)
        else $error("wrap without request");
    property p_toggle;
        timerOverflow[0] && channelIoPinOe[0] && mode0[MF_PULSE]
            ##1 channelIoPinOe[0]
            |-> channelIoPinOut[0] != $past(channelIoPinOut[0]);
    endproperty
    a_toggle: assert property (p_toggle)
        else $error("pin not inverted at wrap");
    property p_stop_low;
        $fell(start0) && mode0[1:0] == MD_TIMER |=> !channelIoPinOut[0];
    endproperty
    a_stop_low: assert property (p_stop_low)
        else $error("pin high after stop");
    property p_stop_quiet;
        !start0 && (mode0[1:0] == MD_TIMER || mode0[1:0] == MD_EVENT)
            |-> !timerOverflow[0];
    endproperty
    a_stop_quiet: assert property (p_stop_quiet)
        else $error("wrap while stopped");
    property p_os_start;
        $rose(channelIoPinOut[0]) && mode0[1:0] == MD_ONESHOT |-> start0;
    endproperty
    a_os_start: assert property (p_os_start)
        else $error("one-shot pulse without start");
    property p_os_end;
        $fell(channelIoPinOut[0]) && mode0[1:0] == MD_ONESHOT && start0
            |=> irqRequest[0];
    endproperty
    a_os_end: assert property (p_os_end)
        else $error("one-shot end without request");
    property p_os_abort;
        $fell(start0) && mode0[1:0] == MD_ONESHOT
            |=> !channelIoPinOut[0] && irqRequest[0];
    endproperty
    a_os_abort: assert property (p_os_abort)
        else $error("one-shot stop wrong");
endmodule

bind mmtc_timer mmtc_timer_sva #(.NCH(NCH)) u_sva (
    .clock(clock), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr),
    .channelIoPinOut(channelIoPinOut), .channelIoPinOe(channelIoPinOe),
    .irqRequest(irqRequest), .irqAck(irqAck), .timerOverflow(timerOverflow));

//--- mmtc_pin_model.sv
// external pin source for channel zero with a set half period
`timescale 1ns/100ps
module mmtc_pin_model (
    // clock and reset
    input wire logic clock,
    input wire logic nrst,
    // bench control
    input wire logic run,
    input wire logic [7:0] halfPeriod,
    // channel side of the pin
    input wire logic pinOe,
    input wire logic pinDrive,
    output logic pinLevel
);
    logic [7:0] count;
    logic source;
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst || !run) begin
            // pull-up: idle line sits high
            count <= 8'h00;
            source <= 1'b1;
        end else if (count == halfPeriod - 8'h01) begin
            count <= 8'h00;
            source <= !source;
        end else begin
            count <= count + 8'h01;
        end
    end
    // channel wins while it drives; no contention modelled
    assign pinLevel = pinOe ? pinDrive : source;
endmodule

//--- multimode_timer_channel_tb.sv
// self-checking bench for the multimode timer channel
`timescale 1ns/100ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin miscompares++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module multimode_timer_channel_tb
    import mmtc_pkg::*;
;
    logic clock, nrst, psel, penable, pwrite, subTick, peerB, run, err;
    logic pready, pslverr, pinLevel;
    logic [7:0] paddr, halfPer;
    logic [4:0] subCnt;
    logic [31:0] pwdata, prdata, rd;
    logic [2:0] pinOut, pinOe, irqRequest, irqAck, timerOverflow;
    int compares, miscompares, cycles;
    mmtc_timer #(.NCH(3)) uut (
        .clock(clock), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .subClockDiv32Tick(subTick),
        .peerTimerBOneOvf(peerB), .peerTimerAZeroOvf(1'b0),
        .channelIoPinIn({2'b11, pinLevel}), .channelIoPinOut(pinOut),
        .channelIoPinOe(pinOe), .irqRequest(irqRequest), .irqAck(irqAck),
        .timerOverflow(timerOverflow));
    mmtc_pin_model model (.clock(clock), .nrst(nrst), .run(run),
        .halfPeriod(halfPer), .pinOe(pinOe[0]), .pinDrive(pinOut[0]),
        .pinLevel(pinLevel));
    ////////////////////////////////////////////////////////////////////////
    initial begin
        clock = 1'b0;
        forever #2.5 clock = !clock;
    end
    // sub clock tick, cycle count and hang guard
    always @(posedge clock) begin
        subCnt <= subCnt + 5'h01;
        subTick <= (subCnt == 5'h1F);
        cycles++;
        if (cycles == 90000) begin
            miscompares++;
            end_sim();
        end
    end
    task automatic end_sim();
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // one apb transfer; waits on pready, releases, idles one cycle
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [15:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {16'h0000, d};
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask
    task automatic peer();
        peerB <= 1'b1;
        @(posedge clock);
        peerB <= 1'b0;
        @(posedge clock);
    endtask
    // cycles until a wrap pulse, bounded
    task automatic waitOvf(output int n);
        n = 0;
        while (timerOverflow[0] !== 1'b1 && n < 70000) begin
            @(posedge clock);
            n++;
        end
    endtask
    task automatic highWidth(output int n);
        n = 0;
        while (pinOut[0] === 1'b1 && n < 48) begin
            @(posedge clock);
            n++;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_timer();
        int n;
        logic [15:0] held;
        apb(1'b0, 8'h0C, 16'h0000);
        `CHK({err, rd}, 33'h0_0000_0000 | 33'h1_0000_0000)
        apb(1'b1, OFS_TIMER, 16'h0001);
        apb(1'b1, OFS_MODE, 16'h0004);
        apb(1'b1, OFS_START, 16'h0001);
        waitOvf(n);
        @(posedge clock);
        waitOvf(n);
        `CHK(n + 1, 2)
        `CHK(irqRequest[0], 1'b1)
        apb(1'b1, OFS_START, 16'h0000);
        @(posedge clock);
        `CHK(pinOut[0], 1'b0)
        apb(1'b0, OFS_TIMER, 16'h0000);
        held = rd[15:0];
        repeat (4) @(posedge clock);
        apb(1'b0, OFS_TIMER, 16'h0000);
        `CHK(rd[15:0], held)
        $display("test timer done");
    endtask
    task automatic t_event();
        apb(1'b1, OFS_TIMER, 16'h0005);
        apb(1'b1, OFS_MODE, 16'h0021);
        apb(1'b1, OFS_START, 16'h0001);
        halfPer <= 8'h04;
        run <= 1'b1;
        repeat (24) @(posedge clock);
        run <= 1'b0;
        apb(1'b1, OFS_START, 16'h0000);
        apb(1'b0, OFS_TIMER, 16'h0000);
        `CHK(rd[15:0], 16'h0002)
        apb(1'b1, OFS_IRQ, 16'h0001);
        apb(1'b1, OFS_TIMER, 16'h0000);
        apb(1'b1, OFS_MODE, 16'h00A1);
        apb(1'b1, OFS_START, 16'h0001);
        peer();
        apb(1'b1, OFS_START, 16'h0000);
        apb(1'b0, OFS_TIMER, 16'h0000);
        `CHK({irqRequest[0], rd[15:0]}, 17'h1_FFFF)
        apb(1'b1, OFS_IRQ, 16'h0001);
        apb(1'b1, OFS_TIMER, 16'h0001);
        apb(1'b1, OFS_MODE, 16'h0081);
        apb(1'b1, OFS_START, 16'h0001);
        peer();
        peer();
        apb(1'b1, OFS_START, 16'h0000);
        apb(1'b0, OFS_TIMER, 16'h0000);
        `CHK({irqRequest[0], rd[15:0]}, 17'h1_0001)
        $display("test event done");
    endtask
    task automatic t_oneshot();
        int n;
        apb(1'b1, OFS_IRQ, 16'h0001);
        apb(1'b1, OFS_TIMER, 16'h0004);
        apb(1'b1, OFS_MODE, 16'h00CE);
        apb(1'b1, OFS_START, 16'h0001);
        apb(1'b1, OFS_ONESHOT, 16'h0001);
        highWidth(n);
        `CHK(n >= 25 && n <= 32 && irqRequest[0], 1'b1)
        apb(1'b1, OFS_ONESHOT, 16'h0001);
        apb(1'b1, OFS_ONESHOT, 16'h0001);
        highWidth(n);
        `CHK(n >= 33 && n <= 40, 1'b1)
        apb(1'b1, OFS_IRQ, 16'h0001);
        apb(1'b1, OFS_TIMER, 16'h0010);
        apb(1'b1, OFS_MODE, 16'h0086);
        peer();
        @(posedge clock);
        `CHK(pinOut[0], 1'b1)
        apb(1'b1, OFS_START, 16'h0000);
        @(posedge clock);
        `CHK({pinOut[0], irqRequest[0]}, 2'b01)
        apb(1'b0, OFS_TIMER, 16'h0000);
        `CHK(rd[15:0], 16'h0010)
        $display("test oneshot done");
    endtask
    task automatic t_measure();
        int n;
        logic [15:0] cap;
        apb(1'b1, OFS_IRQ, 16'h0001);
        apb(1'b1, OFS_MODE, 16'h0003);
        apb(1'b1, OFS_START, 16'h0001);
        halfPer <= 8'h0A;
        run <= 1'b1;
        repeat (15) @(posedge clock);
        `CHK(irqRequest[0], 1'b0)
        n = 0;
        while (irqRequest[0] !== 1'b1 && n < 40) begin
            @(posedge clock);
            n++;
        end
        run <= 1'b0;
        apb(1'b0, OFS_TIMER, 16'h0000);
        cap = rd[15:0];
        `CHK(cap >= 16'h0013 && cap <= 16'h0015, 1'b1)
        apb(1'b1, OFS_TIMER, 16'h1234);
        apb(1'b0, OFS_TIMER, 16'h0000);
        `CHK(rd[15:0], cap)
        apb(1'b1, OFS_IRQ, 16'h0001);
        waitOvf(n);
        @(posedge clock);
        apb(1'b0, OFS_MODE, 16'h0000);
        `CHK({irqRequest[0], rd[11]}, 2'b11)
        apb(1'b1, OFS_MODE, 16'h0803);
        apb(1'b0, OFS_MODE, 16'h0000);
        `CHK(rd[11], 1'b0)
        irqAck <= 3'b001;
        @(posedge clock);
        irqAck <= 3'b000;
        @(posedge clock);
        `CHK(irqRequest[0], 1'b0)
        apb(1'b1, OFS_START, 16'h0000);
        $display("test measure done");
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        {nrst, psel, penable, pwrite, peerB, run, subTick} = 7'h00;
        {paddr, halfPer, subCnt, irqAck} = 24'h00_0000;
        pwdata = 32'h0000_0000;
        repeat (3) @(posedge clock);
        nrst <= 1'b1;
        @(posedge clock);
        t_timer();
        t_event();
        t_oneshot();
        t_measure();
        end_sim();
    end
endmodule
